// file: hw/tcp_pkg.sv
// Shared constants and helpers of the transmit cell interrupt status tree.
package tcp_pkg;
  // ------------------------------------------------------------------
  // Device register map
  // ------------------------------------------------------------------
  localparam int TCP_CH = 4;
  localparam int TCP_CAUSE_W = 6;
  localparam logic [15:0] TCP_BLK_STAT_HI = 16'h0012;
  localparam logic [15:0] TCP_BLK_STAT_LO = 16'h0013;
  localparam logic [15:0] TCP_BLK_EN_LO = 16'h0017;
  localparam logic [15:0] TCP_CH_IND = 16'h0122;
  localparam logic [11:0] TCP_CAUSE_LOW = 12'hf0b;
  localparam logic [11:0] TCP_EN_LOW = 12'hf0f;
  localparam logic [3:0] TCP_CH_NIB0 = 4'h1;
  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int TCP_BLK_BIT = 3;
  localparam int TCP_IND_BIT0 = 2;
  localparam int TCP_EXT = 5;
  localparam int TCP_INS = 4;
  localparam int TCP_EXT_OVF = 3;
  localparam int TCP_INS_OVF = 2;
  localparam int TCP_HEC = 1;
  localparam int TCP_PAR = 0;
  localparam logic [7:0] TCP_BLK_EN_MASK = 8'hf9;
  localparam logic [7:0] TCP_BLK_EN_RST = 8'h00;
  localparam logic [5:0] TCP_SRC_EN_RST = 6'h00;
  // ------------------------------------------------------------------
  // Host register map on AHB-Lite
  // ------------------------------------------------------------------
  localparam logic [7:0] TCP_H_CTRL = 8'h00;
  localparam logic [7:0] TCP_H_STAT = 8'h04;
  localparam logic [7:0] TCP_H_IRQ_STAT = 8'h08;
  localparam logic [7:0] TCP_H_IRQ_MASK = 8'h0c;
  localparam logic [7:0] TCP_H_ACC_ADDR = 8'h10;
  localparam logic [7:0] TCP_H_ACC_DATA = 8'h14;
  localparam logic [7:0] TCP_H_CAUSE_LOG = 8'h18;
  localparam logic [7:0] TCP_H_BLK_LOG = 8'h1c;
  localparam int TCP_C_AUTO = 0;
  localparam int TCP_C_GO_WR = 1;
  localparam int TCP_C_GO_RD = 2;
  localparam int TCP_E_DONE = 0;
  localparam int TCP_E_EXT = 1;
  localparam int TCP_E_ACC = 2;
  localparam int TCP_EV_W = 3;

  // Returns {hit, channel} for a per-channel register with the given low offset.
  function automatic logic [2:0] tcp_chan_hit(input logic [15:0] a, input logic [11:0] low);
    logic [3:0] idx;
    idx = a[15:12] - TCP_CH_NIB0;
    tcp_chan_hit = {(a[11:0] == low) && (idx < 4'(TCP_CH)), idx[1:0]};
  endfunction

  // Builds the address of a per-channel register.
  function automatic logic [15:0] tcp_chan_addr(input logic [1:0] ch, input logic [11:0] low);
    tcp_chan_addr = {TCP_CH_NIB0 + {2'b00, ch}, low};
  endfunction
endpackage

// file: hw/tcp_if.sv
// Byte-wide register port joining the device end and the host end.
`timescale 1ns/10ps
interface tcp_if;
  logic cs;
  logic we;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic irq;
  modport dev
  (
    input cs,
    input we,
    input addr,
    input wdata,
    output rdata,
    output ack,
    output irq
  );
  modport host
  (
    output cs,
    output we,
    output addr,
    output wdata,
    input rdata,
    input ack,
    input irq
  );
endinterface

// file: hw/tcp_cause.sv
// One channel's cause register with its source enables.
`timescale 1ns/10ps
module tcp_cause
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Events and host access.
  input wire logic [tcp_pkg::TCP_CAUSE_W-1:0] event_in,
  input wire logic rd_clr,
  input wire logic en_we,
  input wire logic [tcp_pkg::TCP_CAUSE_W-1:0] en_wdata,
  // State.
  output logic [tcp_pkg::TCP_CAUSE_W-1:0] cause,
  output logic [tcp_pkg::TCP_CAUSE_W-1:0] enable,
  output logic pending
);
  import tcp_pkg::*;

  typedef struct packed {
    logic [TCP_CAUSE_W-1:0] cause;
    logic [TCP_CAUSE_W-1:0] enable;
  } tcp_cause_s;

  tcp_cause_s st;
  tcp_cause_s next_st;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    // A read clears all bits, but an event in the same cycle still sets.
    next_st.cause = (rd_clr ? '0 : st.cause) | event_in;
    if (en_we)
    begin
      next_st.enable = en_wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st.cause <= '0;
      st.enable <= TCP_SRC_EN_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign cause = st.cause;
  assign enable = st.enable;
  assign pending = |(st.cause & st.enable);
endmodule // tcp_cause

// file: hw/tcp_dev.sv
// Device end: block status, channel indicator and per-channel cause registers.
`timescale 1ns/10ps
// What this block does
// - Block status bit 3 flags pending cell interrupt.
// - Host reads both block status bytes first.
// - Host then reads the channel indicator.
// - Indicator bits 5..2 show channels 3..0.
// - Host then reads that channel's cause register.
// - Six cause bits, clear on read, top zero.
// - Extraction event sets cause bit 5.
// - Host then flags an extraction event to software.
// - New extracted cell raises extraction event.
// - Irq needs block and source enables set.
module tcp_dev
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Register port toward the host.
  tcp_if.dev bus,
  // Cause events, six per channel, channel 0 in the lowest bits.
  input wire logic [tcp_pkg::TCP_CH*tcp_pkg::TCP_CAUSE_W-1:0] cause_event,
  // Summary of pending state.
  output logic [tcp_pkg::TCP_CH-1:0] chan_pending,
  output logic block_pending
);
  import tcp_pkg::*;

  typedef struct packed {
    logic [7:0] blk_en;
    logic [7:0] rdata;
    logic ack;
    logic irq;
    logic [TCP_CH-1:0] chan;
    logic blk;
  } tcp_dev_s;

  tcp_dev_s st;
  tcp_dev_s next_st;

  logic take;
  logic rd_take;
  logic wr_take;
  logic hit_stat_hi;
  logic hit_stat_lo;
  logic hit_blk_en;
  logic hit_ind;
  logic [2:0] cause_hit;
  logic [2:0] en_hit;
  logic [TCP_CH-1:0] rd_clr;
  logic [TCP_CH-1:0] en_we;
  logic [TCP_CH-1:0][TCP_CAUSE_W-1:0] cause;
  logic [TCP_CH-1:0][TCP_CAUSE_W-1:0] enable;
  logic [TCP_CH-1:0] pend;
  logic [7:0] ind_byte;
  logic [7:0] lo_byte;
  logic [7:0] rd_byte;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // True when a per-channel decode hit selects the given channel.
  function automatic logic tcp_sel(input logic [2:0] hit, input int ch);
    tcp_sel = hit[2] && (hit[1:0] == 2'(ch));
  endfunction

  // Widens a six-bit channel register to a bus byte; the top bits read zero.
  function automatic logic [7:0] tcp_byte6(input logic [TCP_CAUSE_W-1:0] v);
    tcp_byte6 = 8'h00;
    tcp_byte6[TCP_CAUSE_W-1:0] = v;
  endfunction

  // ------------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------------
  // The guard on ack keeps a request held across its answer from being taken twice.
  assign take = bus.cs && !st.ack;
  assign rd_take = take && !bus.we;
  assign wr_take = take && bus.we;
  assign cause_hit = tcp_chan_hit(bus.addr, TCP_CAUSE_LOW);
  assign en_hit = tcp_chan_hit(bus.addr, TCP_EN_LOW);
  assign hit_stat_hi = (bus.addr == TCP_BLK_STAT_HI);
  assign hit_stat_lo = (bus.addr == TCP_BLK_STAT_LO);
  assign hit_blk_en = (bus.addr == TCP_BLK_EN_LO);
  assign hit_ind = (bus.addr == TCP_CH_IND);

  always_comb
  begin
    for (int i = 0; i < TCP_CH; i++)
    begin
      rd_clr[i] = rd_take && tcp_sel(cause_hit, i);
      en_we[i] = wr_take && tcp_sel(en_hit, i);
    end
  end

  // ------------------------------------------------------------------
  // Per-channel cause registers
  // ------------------------------------------------------------------
  for (genvar g = 0; g < TCP_CH; g++)
  begin : g_chan
    tcp_cause u_cause
    (
      .hclk(hclk),
      .hresetn(hresetn),
      .event_in(cause_event[g*TCP_CAUSE_W +: TCP_CAUSE_W]),
      .rd_clr(rd_clr[g]),
      .en_we(en_we[g]),
      .en_wdata(bus.wdata[TCP_CAUSE_W-1:0]),
      .cause(cause[g]),
      .enable(enable[g]),
      .pending(pend[g])
    );
  end

  // ------------------------------------------------------------------
  // Summary bytes
  // ------------------------------------------------------------------
  always_comb
  begin
    ind_byte = 8'h00;
    ind_byte[TCP_IND_BIT0 +: TCP_CH] = pend;
    lo_byte = 8'h00;
    lo_byte[TCP_BLK_BIT] = |pend;
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  // Byte 1 of the block status belongs to other blocks and reads zero, as do holes.
  always_comb
  begin
    rd_byte = 8'h00;
    if (hit_stat_hi)
    begin
      rd_byte = 8'h00;
    end
    else if (hit_stat_lo)
    begin
      rd_byte = lo_byte;
    end
    else if (hit_blk_en)
    begin
      rd_byte = st.blk_en;
    end
    else if (hit_ind)
    begin
      rd_byte = ind_byte;
    end
    else if (cause_hit[2])
    begin
      rd_byte = tcp_byte6(cause[cause_hit[1:0]]);
    end
    else if (en_hit[2])
    begin
      rd_byte = tcp_byte6(enable[en_hit[1:0]]);
    end
    else
    begin
      rd_byte = 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.ack = take;
    if (wr_take && hit_blk_en)
    begin
      next_st.blk_en = bus.wdata & TCP_BLK_EN_MASK;
    end
    if (rd_take)
    begin
      next_st.rdata = rd_byte;
    end
    next_st.chan = pend;
    next_st.blk = |pend;
    next_st.irq = st.blk_en[TCP_BLK_BIT] && (|pend);
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st.blk_en <= TCP_BLK_EN_RST;
      st.rdata <= 8'h00;
      st.ack <= 1'b0;
      st.irq <= 1'b0;
      st.chan <= '0;
      st.blk <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign bus.rdata = st.rdata;
  assign bus.ack = st.ack;
  assign bus.irq = st.irq;
  assign chan_pending = st.chan;
  assign block_pending = st.blk;
endmodule // tcp_dev

// file: hw/tcp_host.sv
// Host end: walks the interrupt tree and gives software an AHB-Lite view.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/10ps
module tcp_host
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Interrupt to software.
  output logic irq,
  // Register port toward the device.
  tcp_if.host bus
);
  import tcp_pkg::*;

  typedef enum {H_IDLE, H_HI, H_LO, H_IND, H_CAUSE, H_ACC, H_DONE} tcp_state_e;

  typedef struct packed {
    tcp_state_e state;
    logic [TCP_CH-1:0] left;
    logic [1:0] ch;
    logic auto_en;
    logic [TCP_EV_W-1:0] irq_stat;
    logic [TCP_EV_W-1:0] irq_mask;
    logic [15:0] acc_addr;
    logic [7:0] acc_wdata;
    logic [7:0] acc_rdata;
    logic [TCP_CH-1:0][7:0] cause_log;
    logic [23:0] blk_log;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic irq;
    logic cs;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } tcp_host_s;

  tcp_host_s st;
  tcp_host_s next_st;
  logic [TCP_EV_W-1:0] ev;
  logic [TCP_EV_W-1:0] clr;
  logic go_wr;
  logic go_rd;
  logic [TCP_CH-1:0] rest;

  function automatic logic [1:0] tcp_lowest(input logic [TCP_CH-1:0] m);
    tcp_lowest = 2'd0;
    for (int i = TCP_CH - 1; i >= 0; i--)
    begin
      if (m[i])
      begin
        tcp_lowest = 2'(i);
      end
    end
  endfunction

  function automatic tcp_host_s tcp_issue(input tcp_host_s s, input logic w,
                                          input logic [15:0] a, input logic [7:0] d);
    tcp_issue = s;
    tcp_issue.cs = 1'b1;
    tcp_issue.we = w;
    tcp_issue.addr = a;
    tcp_issue.wdata = d;
  endfunction

  always_comb
  begin
    next_st = st;
    ev = '0;
    clr = '0;
    go_wr = 1'b0;
    go_rd = 1'b0;
    rest = st.left;
    // ----------------------------------------------------------------
    // AHB-Lite slave: one wait state, then the data phase completes
    // ----------------------------------------------------------------
    if (st.ap_valid)
    begin
      next_st.ap_valid = 1'b0;
      next_st.hreadyout = 1'b1;
      if (st.ap_write)
      begin
        case (st.ap_addr)
          TCP_H_CTRL:
          begin
            next_st.auto_en = hwdata[TCP_C_AUTO];
            go_wr = hwdata[TCP_C_GO_WR];
            go_rd = hwdata[TCP_C_GO_RD];
          end
          TCP_H_IRQ_STAT: clr = hwdata[TCP_EV_W-1:0];
          TCP_H_IRQ_MASK: next_st.irq_mask = hwdata[TCP_EV_W-1:0];
          TCP_H_ACC_ADDR: next_st.acc_addr = hwdata[15:0];
          TCP_H_ACC_DATA: next_st.acc_wdata = hwdata[7:0];
          default: next_st.hrdata = st.hrdata;
        endcase
      end
      else
      begin
        case (st.ap_addr)
          TCP_H_CTRL: next_st.hrdata = {31'h0, st.auto_en};
          TCP_H_STAT: next_st.hrdata = {30'h0, st.state != H_IDLE, bus.irq};
          TCP_H_IRQ_STAT: next_st.hrdata = {29'h0, st.irq_stat};
          TCP_H_IRQ_MASK: next_st.hrdata = {29'h0, st.irq_mask};
          TCP_H_ACC_ADDR: next_st.hrdata = {16'h0, st.acc_addr};
          TCP_H_ACC_DATA: next_st.hrdata = {24'h0, st.acc_rdata};
          TCP_H_CAUSE_LOG: next_st.hrdata = st.cause_log;
          TCP_H_BLK_LOG: next_st.hrdata = {8'h0, st.blk_log};
          default: next_st.hrdata = 32'h0;
        endcase
      end
    end
    else if (hsel && htrans[1] && hready)
    begin
      next_st.ap_valid = 1'b1;
      next_st.ap_write = hwrite;
      next_st.ap_addr = {haddr[7:2], 2'b00};
      next_st.hreadyout = 1'b0;
    end
    // ----------------------------------------------------------------
    // Service walk over the device
    // ----------------------------------------------------------------
    case (st.state)
      H_IDLE:
      begin
        if (st.auto_en && bus.irq)
        begin
          next_st = tcp_issue(next_st, 1'b0, TCP_BLK_STAT_HI, 8'h00);
          next_st.state = H_HI;
        end
        else if (go_wr || go_rd)
        begin
          next_st = tcp_issue(next_st, go_wr, st.acc_addr, st.acc_wdata);
          next_st.state = H_ACC;
        end
      end
      H_HI:
      begin
        if (bus.ack)
        begin
          next_st.blk_log[23:16] = bus.rdata;
          next_st = tcp_issue(next_st, 1'b0, TCP_BLK_STAT_LO, 8'h00);
          next_st.state = H_LO;
        end
      end
      H_LO:
      begin
        if (bus.ack)
        begin
          next_st.blk_log[15:8] = bus.rdata;
          if (bus.rdata[TCP_BLK_BIT])
          begin
            next_st = tcp_issue(next_st, 1'b0, TCP_CH_IND, 8'h00);
            next_st.state = H_IND;
          end
          else
          begin
            next_st.cs = 1'b0;
            next_st.state = H_DONE;
            ev[TCP_E_DONE] = 1'b1;
          end
        end
      end
      H_IND:
      begin
        if (bus.ack)
        begin
          next_st.blk_log[7:0] = bus.rdata;
          rest = bus.rdata[TCP_IND_BIT0 +: TCP_CH];
          next_st.left = rest;
          next_st.ch = tcp_lowest(rest);
          if (|rest)
          begin
            next_st = tcp_issue(next_st, 1'b0, tcp_chan_addr(tcp_lowest(rest), TCP_CAUSE_LOW),
                                8'h00);
            next_st.state = H_CAUSE;
          end
          else
          begin
            next_st.cs = 1'b0;
            next_st.state = H_DONE;
            ev[TCP_E_DONE] = 1'b1;
          end
        end
      end
      H_CAUSE:
      begin
        if (bus.ack)
        begin
          next_st.cause_log[st.ch] = bus.rdata;
          // Software is told to drain the extraction buffer.
          ev[TCP_E_EXT] = bus.rdata[TCP_EXT];
          rest[st.ch] = 1'b0;
          next_st.left = rest;
          next_st.ch = tcp_lowest(rest);
          if (|rest)
          begin
            next_st = tcp_issue(next_st, 1'b0, tcp_chan_addr(tcp_lowest(rest), TCP_CAUSE_LOW),
                                8'h00);
          end
          else
          begin
            next_st.cs = 1'b0;
            next_st.state = H_DONE;
            ev[TCP_E_DONE] = 1'b1;
          end
        end
      end
      H_ACC:
      begin
        if (bus.ack)
        begin
          if (!st.we)
          begin
            next_st.acc_rdata = bus.rdata;
          end
          next_st.cs = 1'b0;
          next_st.state = H_IDLE;
          ev[TCP_E_ACC] = 1'b1;
        end
      end
      H_DONE: next_st.state = H_IDLE;
      default: next_st.state = H_IDLE;
    endcase
    next_st.irq_stat = (st.irq_stat & ~clr) | ev;
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= '0;
      st.state <= H_IDLE;
      st.hreadyout <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign hrdata = st.hrdata;
  assign hreadyout = st.hreadyout;
  assign hresp = 1'b0;
  assign irq = st.irq;
  assign bus.cs = st.cs;
  assign bus.we = st.we;
  assign bus.addr = st.addr;
  assign bus.wdata = st.wdata;
endmodule // tcp_host

// file: verif/tcp_chk.sv
// Concurrent checks on the register port between the host end and the device end.
`timescale 1ns/10ps
module tcp_chk
  import tcp_pkg::*;
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Register port.
  input wire logic cs,
  input wire logic we,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ------------------------------------------------------------------
  // Port handshake and read fields
  // ------------------------------------------------------------------
  a_ack_one_pulse: assert property (ack |=> !ack)
    else $error("ack stood longer than one cycle");
  a_ack_after_take: assert property (cs && !ack |=> ack)
    else $error("request not answered in the next cycle");
  a_req_held: assert property (cs && !ack |=> cs && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("request changed before its answer");
  a_ind_zero_bits: assert property (ack && !we && addr == TCP_CH_IND |-> rdata[7:6] == 2'h0 && rdata[1:0] == 2'h0)
    else $error("indicator unused bits not zero");
  a_cause_top_zero: assert property (ack && !we && addr[11:0] == TCP_CAUSE_LOW |-> rdata[7:6] == 2'h0)
    else $error("cause bits 7 to 6 not zero");
  a_status_irq_bit: assert property (ack && !we && addr == TCP_BLK_STAT_LO && irq |-> rdata[3])
    else $error("interrupt high but status bit 3 clear");
  // ------------------------------------------------------------------
  // Service walk order
  // ------------------------------------------------------------------
  a_walk_lo_next: assert property (ack && !we && addr == TCP_BLK_STAT_HI |-> ##[1:4] (cs && !we && addr == TCP_BLK_STAT_LO))
    else $error("status byte 0 not read after byte 1");
  a_walk_ind_next: assert property (ack && !we && addr == TCP_BLK_STAT_LO && rdata[3] |-> ##[1:4] (cs && !we && addr == TCP_CH_IND))
    else $error("indicator not read after status bit 3");
  a_walk_cause_next: assert property (ack && !we && addr == TCP_CH_IND && rdata[2] |-> ##[1:4] (cs && !we && addr == 16'h1f0b))
    else $error("channel 0 cause not read after indicator");
endmodule // tcp_chk

// file: verif/tx_cell_proc_irq_status_tree_bench.sv
// Self-checking bench joining the host end and the device end.
`timescale 1ns/10ps
module tx_cell_proc_irq_status_tree_bench;
  import tcp_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic [23:0] cause_event = 24'h0;
  logic [3:0] chan_pending;
  logic block_pending;
  logic [31:0] rd;
  int n_fail = 0;
  int n_compared = 0;
  always #5 hclk = ~hclk;
  tcp_if tcp_if_inst ();
  tcp_dev tcp_dev_inst (.hclk(hclk), .hresetn(hresetn), .bus(tcp_if_inst.dev),
    .cause_event(cause_event), .chan_pending(chan_pending), .block_pending(block_pending));
  tcp_host tcp_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .bus(tcp_if_inst.host));
  tcp_chk tcp_chk_inst (.hclk(hclk), .hresetn(hresetn), .cs(tcp_if_inst.cs),
    .we(tcp_if_inst.we), .addr(tcp_if_inst.addr), .wdata(tcp_if_inst.wdata),
    .rdata(tcp_if_inst.rdata), .ack(tcp_if_inst.ack), .irq(tcp_if_inst.irq));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic report_and_stop();
    $display("Compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic hang(input string what);
    $display("Error %s expected done seen timeout", what);
    n_fail++;
    report_and_stop();
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic wait_ready();
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      i++;
      if (i > 20)
        hang("hreadyout");
      @(posedge hclk);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int i;
    for (i = 0; i < 40; i++)
    begin
      ahb(1'b0, a, 32'h0);
      if ((rd & m) === v)
        return;
    end
    hang("poll");
  endtask
  task automatic dev_wr(input logic [15:0] a, input logic [7:0] d);
    ahb(1'b1, TCP_H_ACC_ADDR, {16'h0, a});
    ahb(1'b1, TCP_H_ACC_DATA, {24'h0, d});
    ahb(1'b1, TCP_H_CTRL, 32'h2);
    poll(TCP_H_STAT, 32'h2, 32'h0);
  endtask
  task automatic dev_rd(input logic [15:0] a);
    ahb(1'b1, TCP_H_ACC_ADDR, {16'h0, a});
    ahb(1'b1, TCP_H_CTRL, 32'h4);
    poll(TCP_H_STAT, 32'h2, 32'h0);
    ahb(1'b0, TCP_H_ACC_DATA, 32'h0);
  endtask
  task automatic pulse(input logic [23:0] ev);
    @(posedge hclk);
    cause_event <= ev;
    @(posedge hclk);
    cause_event <= 24'h0;
    repeat (3) @(posedge hclk);
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    chk("hresp", 32'h0, {31'h0, hresp});
    dev_rd(TCP_BLK_EN_LO);
    chk("block enable reset", 32'h0, rd);
    dev_rd(16'h1f0f);
    chk("source enable reset", 32'h0, rd);
    dev_wr(TCP_BLK_EN_LO, 8'hff);
    dev_rd(TCP_BLK_EN_LO);
    chk("block enable mask", {24'h0, TCP_BLK_EN_MASK}, rd);
    dev_wr(TCP_BLK_EN_LO, 8'h00);
    dev_rd(16'h0050);
    chk("unmapped device read", 32'h0, rd);
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped host read", 32'h0, rd);
  endtask
  task automatic t_causes();
    int b;
    for (b = 0; b < 6; b++)
    begin
      pulse(24'h1 << (6 + b));
      chk("masked pending", 32'h0, {28'h0, chan_pending});
      dev_rd(16'h2f0b);
      chk("cause set", 32'h1 << b, rd);
      dev_rd(16'h2f0b);
      chk("cause cleared", 32'h0, rd);
    end
  endtask
  task automatic t_enable();
    dev_wr(16'h1f0f, 8'h01);
    pulse(24'h1);
    chk("chan pending", 32'h1, {28'h0, chan_pending});
    chk("block pending", 32'h1, {31'h0, block_pending});
    chk("irq gated", 32'h0, {31'h0, tcp_if_inst.irq});
    dev_wr(TCP_BLK_EN_LO, 8'h08);
    repeat (2) @(posedge hclk);
    chk("irq enabled", 32'h1, {31'h0, tcp_if_inst.irq});
    ahb(1'b0, TCP_H_STAT, 32'h0);
    chk("host view of device irq", 32'h1, rd & 32'h1);
  endtask
  task automatic t_walk();
    dev_wr(16'h3f0f, 8'h20);
    pulse(24'h1 << 17);
    chk("two pending", 32'h5, {28'h0, chan_pending});
    ahb(1'b1, TCP_H_IRQ_MASK, 32'h0);
    ahb(1'b1, TCP_H_IRQ_STAT, 32'h7);
    ahb(1'b1, TCP_H_CTRL, 32'h1);
    poll(TCP_H_IRQ_STAT, 32'h1, 32'h1);
    ahb(1'b1, TCP_H_CTRL, 32'h0);
    chk("walk flags", 32'h3, rd & 32'h3);
    ahb(1'b0, TCP_H_BLK_LOG, 32'h0);
    chk("walk status log", 32'h00000814, rd);
    ahb(1'b0, TCP_H_CAUSE_LOG, 32'h0);
    chk("walk cause log", 32'h00200001, rd & 32'h00ff00ff);
    chk("cleared by walk", 32'h0, {28'h0, chan_pending});
    chk("irq masked", 32'h0, {31'h0, irq});
    ahb(1'b1, TCP_H_IRQ_MASK, 32'h2);
    repeat (2) @(posedge hclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    ahb(1'b1, TCP_H_IRQ_STAT, 32'h2);
    repeat (2) @(posedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    ahb(1'b0, TCP_H_IRQ_STAT, 32'h0);
    chk("ext flag cleared", 32'h0, rd & 32'h2);
  endtask
  task automatic t_midreset();
    pulse(24'h1);
    chk("pending before reset", 32'h1, {28'h0, chan_pending});
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk("pending after reset", 32'h0, {28'h0, chan_pending});
    chk("device irq after reset", 32'h0, {31'h0, tcp_if_inst.irq});
    chk("hreadyout after reset", 32'h1, {31'h0, hreadyout});
    dev_rd(16'h1f0b);
    chk("cause after reset", 32'h0, rd);
    dev_rd(16'h1f0f);
    chk("source enable after reset", 32'h0, rd);
    dev_rd(TCP_BLK_EN_LO);
    chk("block enable after reset", 32'h0, rd);
  endtask
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_causes();
    t_enable();
    t_walk();
    t_midreset();
    report_and_stop();
  end
endmodule // tx_cell_proc_irq_status_tree_bench
